// ---- pkg/unr_cfg.svh ----
`ifndef UNR_CFG_SVH
`define UNR_CFG_SVH

// Global address decode
`define UNR_BASE_BLOCK    8'h02
`define UNR_BASE_NONBLOCK 8'h03
`define UNR_OFF_STAT1     8'h44
`define UNR_OFF_CTRL3     8'h46
`define UNR_OFF_DATA      8'h47

// Control three field positions
`define UNR_C3_RX9   7
`define UNR_C3_TX9   6
`define UNR_C3_DIR   5
`define UNR_C3_INV   4
`define UNR_C3_OVERRUN_IRQ_ENABLE  3
`define UNR_C3_NOISE_IRQ_ENABLE  2
`define UNR_C3_FRAMING_IRQ_ENABLE  1
`define UNR_C3_PARITY_IRQ_ENABLE  0

// Status one field positions
`define UNR_S1_TXSPACE 7
`define UNR_S1_RXFULL  5
`define UNR_S1_OVR     3

// Widths, depths and reset values
`define UNR_FIFO_DEPTH 16
`define UNR_TXW_BITS   9
`define UNR_CTRL_RST   7'h00
`define UNR_BYTE_RST   8'h00
`define UNR_ERR_RST    4'h0

`endif

// ---- pkg/unr_pkg.sv ----
package unr_pkg;

   // Register bus request
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } unr_bus_t;

   // Character from the receive shifter
   typedef struct packed {
      logic       valid;
      logic       ninth;
      logic [7:0] data;
      logic       noise;
      logic       framing;
      logic       parity;
   } unr_rx_t;

   // Character toward the transmit shifter
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } unr_tx_t;

endpackage : unr_pkg

// ---- design/unr_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module unr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,  // Clock
   input  wire logic             reset,     // Async reset
   input  wire logic             inValid,   // Write request
   output logic                  inReady,   // Not full
   input  wire logic [WIDTH-1:0] inData,    // Write word
   output logic                  outValid,  // Not empty
   input  wire logic             outReady,  // Read request
   output logic      [WIDTH-1:0] outData    // Head word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   // Honest full and empty from the count
   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Storage
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // Pointers and fill level
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) wrPtr_q <= wrPtr_q + AW'(1);
         if (pop)  rdPtr_q <= rdPtr_q + AW'(1);
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : unr_fifo

`default_nettype wire

// ---- design/unr_core.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "unr_cfg.svh"

// What this block does
// - In nine-bit mode bit 7 of control three reads the ninth received bit.
// - In nine-bit mode bit 6 of control three is the ninth transmit bit above the written byte.
// - The whole nine-bit value is captured when the data port is written, so the ninth bit goes first.
// - The ninth transmit bit is kept between data writes and reused for every character.
// - In single-wire mode bit 5 of control three sets the transmit pin direction, 1 meaning output.
// - With bit 4 set every level on the transmit pin is inverted, idle and break included.
// - With bit 3 set the overrun flag requests an interrupt.
// - With bit 2 set the noise flag requests an interrupt.
// - With bit 1 set the framing error flag requests an interrupt.
// - With bit 0 set the parity error flag requests an interrupt.
// - The data port at 0x47 reads the receive buffer and writes the transmit buffer.
// - Data port reads also act as steps of the flag clearing sequences.
// - Offsets decode against base 0x0200 for blocking and 0x300 for non-blocking access.
// - Noise, framing and parity flags clear on a status read with the flag set then a data read.
module unr_core
   import unr_pkg::*;
(
   input  wire logic     core_clk,      // 100 MHz clock
   input  wire logic     reset,         // Async, active high
   input  wire unr_bus_t busReq,        // Register request
   output logic [7:0]    busRdata_q,    // Read data, next cycle
   input  wire logic     nineBitMode,   // Nine-bit format
   input  wire logic     loopSelect,    // Loop select
   input  wire logic     rxSrcSelect,   // Receiver source select
   input  wire unr_rx_t  rxIn,          // Received character
   output unr_tx_t       txWord_q,      // Character to shifter
   output logic          txValid_q,     // Character waiting
   input  wire logic     txReady,       // Shifter takes it
   input  wire logic     txLevel,       // Shifter line level
   output logic          txPinOut_q,    // Pin output value
   output logic          txPinOe_q,     // Pin output enable
   input  wire logic     txPinIn,       // Pin input value
   output logic          pinLevel_q,    // Synced pin level
   output logic          errIrq_q       // Error interrupt
);

   // Control three writable bits [6:0]
   logic [6:0] ctrl_q;
   logic [7:0] rxByte_q;
   logic       rxNinth_q;
   logic       rxFull_q;
   logic       armFull_q;
   logic [3:0] err_q;
   logic [3:0] errArm_q;
   logic [3:0] errSet;
   logic [3:0] errClr;
   logic       pinMeta_q;

   logic       hitBase;
   logic       hitStat;
   logic       hitCtrl;
   logic       hitData;
   logic       statRd;
   logic       dataRd;
   logic       dataWr;
   logic       ctrlWr;
   logic       rxAccept;
   logic       clrFull;

   logic       fifoInReady;
   logic       fifoOutValid;
   logic       fifoOutReady;
   logic [8:0] fifoOutData;
   unr_tx_t    pushWord;
   logic       singleWire;

   // Address decode against both global windows
   assign hitBase = (busReq.addr[15:8] == `UNR_BASE_BLOCK)
                 || (busReq.addr[15:8] == `UNR_BASE_NONBLOCK);
   assign hitStat = hitBase && (busReq.addr[7:0] == `UNR_OFF_STAT1);
   assign hitCtrl = hitBase && (busReq.addr[7:0] == `UNR_OFF_CTRL3);
   assign hitData = hitBase && (busReq.addr[7:0] == `UNR_OFF_DATA);
   assign statRd  = busReq.rd && hitStat;
   assign dataRd  = busReq.rd && hitData;
   assign dataWr  = busReq.wr && hitData;
   assign ctrlWr  = busReq.wr && hitCtrl;

   // Control three storage, ninth tx bit kept
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= `UNR_CTRL_RST;
      end else if (ctrlWr) begin
         ctrl_q <= busReq.wdata[6:0];
      end
   end

   // Flag clearing steps from data reads
   assign clrFull = dataRd && armFull_q;
   assign errClr  = dataRd ? errArm_q : `UNR_ERR_RST;

   // New character taken if buffer free or freed now
   assign rxAccept = rxIn.valid && (!rxFull_q || clrFull);
   assign errSet   = {rxIn.valid && !rxAccept,
                      rxAccept && rxIn.noise,
                      rxAccept && rxIn.framing,
                      rxAccept && rxIn.parity};

   // Receive buffer and ninth bit
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rxByte_q  <= `UNR_BYTE_RST;
         rxNinth_q <= 1'b0;
      end else if (rxAccept) begin
         rxByte_q  <= rxIn.data;
         rxNinth_q <= rxIn.ninth & nineBitMode;
      end
   end

   // Buffer full flag, set wins over clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rxFull_q <= 1'b0;
      end else begin
         rxFull_q <= rxAccept || (rxFull_q && !clrFull);
      end
   end

   // Error flags, set wins over clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         err_q <= `UNR_ERR_RST;
      end else begin
         err_q <= (err_q & ~errClr) | errSet;
      end
   end

   // Arming by a status read, dropped by a data read
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         errArm_q  <= `UNR_ERR_RST;
         armFull_q <= 1'b0;
      end else if (statRd) begin
         errArm_q  <= err_q;
         armFull_q <= rxFull_q;
      end else if (dataRd) begin
         errArm_q  <= `UNR_ERR_RST;
         armFull_q <= 1'b0;
      end
   end

   // Registered read data, unmapped reads zero
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busRdata_q <= `UNR_BYTE_RST;
      end else if (busReq.rd) begin
         busRdata_q <= `UNR_BYTE_RST;
         if (hitCtrl) begin
            busRdata_q[6:0]         <= ctrl_q;
            busRdata_q[`UNR_C3_RX9] <= rxNinth_q & nineBitMode;
         end else if (hitData) begin
            busRdata_q <= rxByte_q;
         end else if (hitStat) begin
            busRdata_q[3:0]             <= err_q;
            busRdata_q[`UNR_S1_RXFULL]  <= rxFull_q;
            busRdata_q[`UNR_S1_TXSPACE] <= fifoInReady;
         end
      end
   end

   // Nine-bit word captured at the data write
   assign pushWord.ninth = nineBitMode & ctrl_q[`UNR_C3_TX9];
   assign pushWord.data  = busReq.wdata;

   // Transmit buffer queue, write dropped when full
   unr_fifo #(
      .WIDTH (`UNR_TXW_BITS),
      .DEPTH (`UNR_FIFO_DEPTH)
   ) u_txFifo (
      .core_clk (core_clk),
      .reset    (reset),
      .inValid  (dataWr),
      .inReady  (fifoInReady),
      .inData   (pushWord),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // Output stage refills when empty or taken
   assign fifoOutReady = !txValid_q || txReady;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         txWord_q  <= '0;
         txValid_q <= 1'b0;
      end else if (fifoOutReady) begin
         txValid_q <= fifoOutValid;
         if (fifoOutValid) begin
            txWord_q <= fifoOutData;
         end
      end
   end

   // Pin level, polarity and direction
   assign singleWire = loopSelect && rxSrcSelect;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         txPinOut_q <= 1'b1;
         txPinOe_q  <= 1'b0;
      end else begin
         txPinOut_q <= txLevel ^ ctrl_q[`UNR_C3_INV];
         txPinOe_q  <= singleWire ? ctrl_q[`UNR_C3_DIR]
                                  : 1'b1;
      end
   end

   // Two-flop sync of the pin input
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinMeta_q  <= 1'b1;
         pinLevel_q <= 1'b1;
      end else begin
         pinMeta_q  <= txPinIn;
         pinLevel_q <= pinMeta_q;
      end
   end

   // Error interrupt from gated flags
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         errIrq_q <= 1'b0;
      end else begin
         errIrq_q <= |(err_q & ctrl_q[3:0]);
      end
   end

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence statSeen_s;
      statRd && (err_q != 4'h0);
   endsequence

   sequence dataNext_s;
      dataRd && !rxIn.valid;
   endsequence

   ctrl_read_ninth_a: assert property (
      busReq.rd && hitCtrl |=>
         busRdata_q[7] == $past(rxNinth_q & nineBitMode))
      else $error("ninth receive bit not read back");

   tx_ninth_word_a: assert property (
      dataWr && fifoInReady && !fifoOutValid && !txValid_q |=>
         ##1 txValid_q && txWord_q.ninth == $past(pushWord.ninth, 2))
      else $error("ninth transmit bit not carried");

   tx_ninth_keep_a: assert property (
      !ctrlWr |=> ctrl_q[`UNR_C3_TX9] == $past(ctrl_q[`UNR_C3_TX9]))
      else $error("ninth transmit bit changed without write");

   pin_dir_a: assert property (
      singleWire && ctrl_q[`UNR_C3_DIR] |=> txPinOe_q)
      else $error("pin not driven in single-wire output");

   pin_release_a: assert property (
      singleWire && !ctrl_q[`UNR_C3_DIR] |=> !txPinOe_q)
      else $error("pin driven while set as input");

   pin_invert_a: assert property (
      1'b1 |=> txPinOut_q == ($past(txLevel) ^ $past(ctrl_q[`UNR_C3_INV])))
      else $error("pin polarity wrong");

   err_irq_a: assert property (
      1'b1 |=> errIrq_q == |($past(err_q) & $past(ctrl_q[3:0])))
      else $error("error interrupt mismatch");

   overrun_irq_a: assert property (
      rxIn.valid && rxFull_q && !clrFull && ctrl_q[`UNR_C3_OVERRUN_IRQ_ENABLE]
         && !ctrlWr |=> ##1 errIrq_q)
      else $error("overrun interrupt missing");

   data_read_a: assert property (
      dataRd |=> busRdata_q == $past(rxByte_q))
      else $error("data port read wrong");

   flag_clear_a: assert property (
      statSeen_s ##1 (!busReq.rd && !rxIn.valid) ##1 dataNext_s
         |=> (err_q & $past(errArm_q)) == 4'h0)
      else $error("error flags not cleared by sequence");

   full_clear_a: assert property (
      rxFull_q && statRd ##1 dataNext_s |=> !rxFull_q)
      else $error("buffer full not cleared by data read");

endmodule : unr_core

`default_nettype wire

// ---- dv/unr_tx_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

module unr_tx_partner
   import unr_pkg::*;
(
   core_clk,  // Clock
   stall,     // Hold off taking words
   txWord,    // Offered word
   txValid,   // Word waiting
   txReady    // Shifter takes word
);
   input  wire logic    core_clk;
   input  wire logic    stall;
   input  wire unr_tx_t txWord;
   input  wire logic    txValid;
   output logic         txReady;

   int      seed = 78;
   unr_tx_t got[$];

   // Random acceptance, changed only at the falling edge
   initial txReady = 1'b0;
   always @(negedge core_clk) begin
      txReady <= !stall && $random(seed) % 2 != 0;
   end

   // Keep every word that crossed, ninth bit included
   always @(posedge core_clk) begin
      if (txValid && txReady) got.push_back(txWord);
   end
endmodule : unr_tx_partner

`default_nettype wire

// ---- dv/uart_ninth_bit_irq_data_regs_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module uart_ninth_bit_irq_data_regs_bench;
   import unr_pkg::*;
   localparam logic [15:0] CTRL = 16'h0246, STAT = 16'h0244, DATA = 16'h0347;
   logic       core_clk, reset, nineBitMode, loopSelect, rxSrcSelect, txReady, txLevel, txPinIn, stall;
   logic       txValid_q, txPinOut_q, txPinOe_q, pinLevel_q, errIrq_q;
   logic [7:0] busRdata_q, rdv, d, en;
   logic [2:0] fl;
   logic       nb, ovr;
   unr_bus_t   busReq;
   unr_rx_t    rxIn;
   unr_tx_t    txWord_q;
   unr_tx_t    sent[$];
   int         seed = 78, nErrors = 0, totalChecks = 0;

   unr_core DUT (.core_clk(core_clk), .reset(reset), .busReq(busReq), .busRdata_q(busRdata_q),
      .nineBitMode(nineBitMode), .loopSelect(loopSelect), .rxSrcSelect(rxSrcSelect), .rxIn(rxIn),
      .txWord_q(txWord_q), .txValid_q(txValid_q), .txReady(txReady), .txLevel(txLevel),
      .txPinOut_q(txPinOut_q), .txPinOe_q(txPinOe_q), .txPinIn(txPinIn), .pinLevel_q(pinLevel_q),
      .errIrq_q(errIrq_q));

   unr_tx_partner partner (.core_clk(core_clk), .stall(stall), .txWord(txWord_q), .txValid(txValid_q),
      .txReady(txReady));

   // Comparisons
   task automatic checkWord(input logic [8:0] got, input logic [8:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask : checkWord
   task automatic checkBit(input logic got, input logic exp);
      totalChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
      end
   endtask : checkBit

   // Register bus cycles, one strobe cycle each
   task automatic busWrite(input logic [15:0] a, input logic [7:0] v);
      @(negedge core_clk);
      busReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(negedge core_clk);
      busReq.wr = 1'b0;
   endtask : busWrite
   task automatic busRead(input logic [15:0] a, output logic [7:0] v);
      @(negedge core_clk);
      busReq.addr = a;
      busReq.rd = 1'b1;
      @(negedge core_clk);
      busReq.rd = 1'b0;
      v = busRdata_q;
   endtask : busRead

   // One received character pulse
   task automatic rxChar(input logic n9, input logic [7:0] v, input logic [2:0] f);
      @(negedge core_clk);
      rxIn = '{valid: 1'b1, ninth: n9, data: v, noise: f[2], framing: f[1], parity: f[0]};
      @(negedge core_clk);
      rxIn.valid = 1'b0;
   endtask : rxChar

   // Error request from flags and enables
   function automatic logic expIrq(input logic [3:0] f, input logic [3:0] e);
      return |(f & e);
   endfunction : expIrq

   task automatic completeRun;
      if (nErrors == 0 && totalChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : completeRun

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Watchdog
   initial begin
      repeat (6000) @(posedge core_clk);
      nErrors++;
      completeRun();
   end

   // Main sequence
   initial begin
      {reset, stall, txLevel, txPinIn} = 4'hF;
      {nineBitMode, loopSelect, rxSrcSelect} = 3'h0;
      busReq = '0;
      rxIn = '0;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      busRead(CTRL, rdv);
      checkWord({1'b0, rdv}, 9'h000);
      busRead(DATA, rdv);
      checkWord({1'b0, rdv}, 9'h000);
      checkBit(txPinOut_q, 1'b1);
      // Both bases reach the same register, others do not
      for (int i = 0; i < 4; i++) begin
         d = 8'(($random(seed) & 32'h4F) | 32'h01);
         busWrite({i[0] ? 8'h03 : 8'h02, 8'h46}, d);
         busWrite({8'h04, 8'h46}, 8'hFF);
         busRead({i[0] ? 8'h02 : 8'h03, 8'h46}, rdv);
         checkWord({1'b0, rdv}, {1'b0, d & 8'h7F});
         busRead({8'h01, 8'h46}, rdv);
         checkWord({1'b0, rdv}, 9'h000);
      end
      // Pin polarity and single-wire direction
      {loopSelect, rxSrcSelect} = 2'h3;
      for (int i = 0; i < 5; i++) begin
         busWrite(CTRL, {2'h0, i[1], i[0], 4'h0});
         if (i == 4) loopSelect = 1'b0;
         txLevel = $random(seed) % 2 != 0;
         txPinIn = ~txLevel;
         repeat (2) @(negedge core_clk);
         checkBit(txPinOut_q, txLevel ^ i[0]);
         checkBit(txPinOe_q, i[1] | loopSelect == 1'b0);
         checkBit(pinLevel_q, txPinIn);
      end
      // Fill the transmit path while the shifter stalls, ninth bit kept
      nineBitMode = 1'b1;
      busWrite(CTRL, 8'h40);
      for (int i = 0; i < 18; i++) begin
         if (i == 5) busWrite(CTRL, 8'h00);
         d = 8'($random(seed));
         if (i == 0) d = 8'hFF;
         busWrite(DATA, d);
         if (i < 17) sent.push_back({i < 5, d});
      end
      busRead(STAT, rdv);
      checkBit(rdv[7], 1'b0);
      stall = 1'b0;
      for (int i = 0; i < 500 && partner.got.size() < 17; i++) @(negedge core_clk);
      checkWord(9'(partner.got.size()), 9'h011);
      for (int i = 0; i < 17; i++) checkWord(partner.got[i], sent[i]);
      // Received characters, error requests and flag clearing
      for (int k = 0; k < 6; k++) begin
         en = 8'($random(seed) & 32'h0F);
         fl = 3'($random(seed));
         if (k < 2) fl = 3'h7;
         if (k < 2) en = k == 0 ? 8'h00 : 8'h0F;
         ovr = k % 2 != 0;
         nb = $random(seed) % 2 != 0;
         d = 8'($random(seed));
         busWrite(CTRL, en);
         rxChar(nb, d, fl);
         if (ovr) rxChar(~nb, ~d, 3'h0);
         repeat (3) @(negedge core_clk);
         checkBit(errIrq_q, expIrq({ovr, fl}, en[3:0]));
         busRead(CTRL, rdv);
         checkWord({1'b0, rdv}, {1'b0, nb, 3'h0, en[3:0]});
         busRead(STAT, rdv);
         checkWord({1'b0, rdv}, {5'h0A, ovr, fl});
         busRead(DATA, rdv);
         checkWord({1'b0, rdv}, {1'b0, d});
         repeat (3) @(negedge core_clk);
         checkBit(errIrq_q, 1'b0);
         busRead(STAT, rdv);
         checkWord({1'b0, rdv}, 9'h080);
      end
      completeRun();
   end
endmodule : uart_ninth_bit_irq_data_regs_bench

`default_nettype wire
